// *** rtl/lbm_pkg.sv ***
// constants, state codes and field layout for the local bus address/data mux
// assumes nothing beyond a SystemVerilog compiler
package lbm_pkg;
   localparam int          AD_W      = 32;
   localparam int          LANES     = 4;
   localparam int          LANE_W    = 8;
   localparam int          ADDR_LSB  = 2;
   localparam int          CNT_W     = 2;
   localparam int          SYNC_W    = AD_W + 2;
   localparam logic [7:0]  LANE_FILL = 8'h00;
   localparam logic [31:0] AD_ZERO   = 32'h0000_0000;
   localparam logic [1:0]  CNT_ZERO  = 2'h0;
   localparam logic [1:0]  CNT_ONE   = 2'h1;

   // transfer-count code: 0 = one transfer ... 3 = four transfers
   typedef logic [CNT_W-1:0] lbm_cnt_t;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_ADDR = 5'h02,
      ST_DATA = 5'h04,
      ST_HOLD = 5'h08,
      ST_HALT = 5'h10
   } lbm_state_t;
endpackage

// *** rtl/lbm_sync.sv ***
// two-stage synchroniser for signals arriving from the pins
// assumes the inputs are levels that stay stable for several clocks
`timescale 1ns/1ps
module lbm_sync #(
   parameter int W = 1
) (
   input  wire logic         mclk_in,
   input  wire logic         rstn_in,
   input  wire logic [W-1:0] d_in,
   input  wire logic [W-1:0] rst_val_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] stage1;
   logic [W-1:0] stage2;

   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         stage1 <= '0;
         stage2 <= '0;
      end else begin
         stage1 <= d_in;
         stage2 <= stage1;
      end
   end

   // reset value only shows while reset is low, never a register input
   assign q_out = rstn_in ? stage2 : rst_val_in;
endmodule

// *** rtl/lbm_ad_mux.sv ***
// multiplexed 32-bit local address/data lines with address strobe
// assumes a core-side request port on mclk_in and pins from memory
// Notes on behaviour
// RQ1: one 32-bit line set carries address and data
// RQ2: address cycle: word address bits 31:2
// RQ3: low two bits state transfer count
// RQ4: data sits on contiguous byte lanes
// RQ5: unused write lanes driven to zero
// RQ6: outside logic ignores count for DMA/translation
// RQ7: lines float while reset asserted
// RQ8: lines float during bus hold
// RQ9: lines keep driving while halted
// RQ10: inputs sampled synchronously as levels
// RQ11: code 00..11 means one to four transfers
// RQ12: halt shows bits 31:2 of last write data or address, bits 1:0 of address
// RQ13: strobe low for whole address cycle
// RQ14: lines released during read data cycles
`timescale 1ns/1ps
module lbm_ad_mux (
   input  wire logic                      mclk_in,
   input  wire logic                      rstn_in,
   input  wire logic                      req_valid_in,
   output logic                           req_ready_out,
   input  wire logic                      req_write_in,
   input  wire logic [lbm_pkg::AD_W-1:2]  req_addr_in,
   input  wire lbm_pkg::lbm_cnt_t         req_count_in,
   input  wire logic [lbm_pkg::AD_W-1:0]  wr_data_in,
   input  wire logic [lbm_pkg::LANES-1:0] wr_be_in,
   output logic                           wr_take_out,
   output logic [lbm_pkg::AD_W-1:0]       rd_data_out,
   output logic                           rd_valid_out,
   input  wire logic                      halt_in,
   input  wire logic                      hold_req_in,
   output logic                           hold_ack_out,
   input  wire logic                      ready_n_in,
   input  wire logic [lbm_pkg::AD_W-1:0]  local_addr_data_lines_in,
   output logic [lbm_pkg::AD_W-1:0]       local_addr_data_lines_out,
   output logic                           local_addr_data_lines_oe_out,
   output logic                           address_strobe_n_out
);
   import lbm_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [SYNC_W-1:0] sync_q;
   logic [AD_W-1:0]   lines_s;
   logic              ready_s;
   logic              hold_s;

   lbm_sync #(
      .W (SYNC_W)
   ) u_sync (
      .mclk_in    (mclk_in),
      .rstn_in    (rstn_in),
      .d_in       ({hold_req_in, ready_n_in, local_addr_data_lines_in}),
      .rst_val_in ({1'b0, 1'b1, AD_ZERO}),
      .q_out      (sync_q)
   );

   assign lines_s = sync_q[AD_W-1:0]; // RQ10
   assign ready_s = !sync_q[AD_W];
   assign hold_s  = sync_q[AD_W+1];

   ////////////////////////////////////////////////////////////////////////////
   // write lane mask

   logic [AD_W-1:0] be_mask;
   logic [AD_W-1:0] wr_masked;

   genvar gi;
   generate
      for (gi = 0; gi < LANES; gi++) begin : g_lane
         assign be_mask[gi*LANE_W +: LANE_W]   = {LANE_W{wr_be_in[gi]}}; // RQ4
         assign wr_masked[gi*LANE_W +: LANE_W] = wr_be_in[gi] ?
                                                 wr_data_in[gi*LANE_W +: LANE_W] :
                                                 LANE_FILL; // RQ5
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // sequencer

   lbm_state_t      st;
   lbm_state_t      next_st;
   logic            is_write;
   logic            next_is_write;
   lbm_cnt_t        count;
   lbm_cnt_t        next_count;
   lbm_cnt_t        beat;
   lbm_cnt_t        next_beat;
   logic            last_write;
   logic            next_last_write;
   logic [AD_W-1:0] last_word;
   logic [AD_W-1:0] next_last_word;
   logic [AD_W-1:0] last_wdata;
   logic [AD_W-1:0] next_last_wdata;
   logic [AD_W-1:0] lad;
   logic [AD_W-1:0] next_lad;
   logic            lad_oe;
   logic            next_lad_oe;
   logic            ads_n;
   logic            next_ads_n;
   logic [AD_W-1:0] rd_data;
   logic [AD_W-1:0] next_rd_data;
   logic            rd_valid;
   logic            next_rd_valid;
   logic            take;

   assign req_ready_out = (st == ST_IDLE) && !hold_s && !halt_in;
   assign take          = (st == ST_DATA) && ready_s;
   assign wr_take_out   = take && is_write;

   always_comb begin
      next_st         = st;
      next_is_write   = is_write;
      next_count      = count;
      next_beat       = beat;
      next_last_write = last_write;
      next_last_word  = last_word;
      next_last_wdata = last_wdata;
      next_lad        = lad;
      next_lad_oe     = lad_oe;
      next_ads_n      = 1'b1;
      next_rd_data    = rd_data;
      next_rd_valid   = 1'b0;
      unique case (st)
         ST_IDLE: begin
            if (hold_s) begin
               next_st     = ST_HOLD;
               next_lad_oe = 1'b0; // RQ8
            end else if (halt_in) begin
               next_st     = ST_HALT;
               next_lad_oe = 1'b1; // RQ9
               next_lad    = {(last_write ? last_wdata[AD_W-1:ADDR_LSB] :
                               last_word[AD_W-1:ADDR_LSB]),
                              last_word[ADDR_LSB-1:0]}; // RQ12
            end else if (req_valid_in) begin
               next_st        = ST_ADDR;
               next_is_write  = req_write_in;
               next_count     = req_count_in; // RQ11
               next_beat      = CNT_ZERO;
               next_lad       = {req_addr_in, req_count_in}; // RQ1 RQ2 RQ3
               next_last_word = {req_addr_in, req_count_in};
               next_lad_oe    = 1'b1;
               next_ads_n     = 1'b0; // RQ13
            end else begin
               next_lad_oe = 1'b0;
            end
         end
         ST_ADDR: begin
            next_st         = ST_DATA;
            next_last_write = is_write;
            if (is_write) begin
               next_lad        = wr_masked; // RQ5
               next_last_wdata = wr_masked;
               next_lad_oe     = 1'b1;
            end else begin
               next_lad_oe = 1'b0; // RQ14
            end
         end
         ST_DATA: begin
            if (is_write) begin
               next_lad        = wr_masked; // RQ4
               next_last_wdata = lad;
            end else if (ready_s) begin
               next_rd_data  = lines_s; // RQ10
               next_rd_valid = 1'b1;
            end
            if (take) begin
               next_beat = beat + CNT_ONE;
               if (beat == count) begin
                  next_st     = ST_IDLE;
                  next_lad_oe = 1'b0;
               end
            end
         end
         ST_HOLD: begin
            next_lad_oe = 1'b0; // RQ8
            if (!hold_s) begin
               next_st = ST_IDLE;
            end
         end
         ST_HALT: begin
            if (!halt_in) begin
               next_st     = ST_IDLE;
               next_lad_oe = 1'b0;
            end
         end
         default: begin
            next_st     = ST_IDLE;
            next_lad_oe = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         st         <= ST_IDLE;
         is_write   <= 1'b0;
         count      <= CNT_ZERO;
         beat       <= CNT_ZERO;
         last_write <= 1'b0;
         last_word  <= AD_ZERO;
         last_wdata <= AD_ZERO;
         lad        <= AD_ZERO;
         lad_oe     <= 1'b0; // RQ7
         ads_n      <= 1'b1;
         rd_data    <= AD_ZERO;
         rd_valid   <= 1'b0;
      end else begin
         st         <= next_st;
         is_write   <= next_is_write;
         count      <= next_count;
         beat       <= next_beat;
         last_write <= next_last_write;
         last_word  <= next_last_word;
         last_wdata <= next_last_wdata;
         lad        <= next_lad;
         lad_oe     <= next_lad_oe;
         ads_n      <= next_ads_n;
         rd_data    <= next_rd_data;
         rd_valid   <= next_rd_valid;
      end
   end

   assign local_addr_data_lines_out    = lad;
   assign local_addr_data_lines_oe_out = lad_oe;
   assign address_strobe_n_out         = ads_n;
   assign rd_data_out                  = rd_data;
   assign rd_valid_out                 = rd_valid;
   assign hold_ack_out                 = (st == ST_HOLD);

   ////////////////////////////////////////////////////////////////////////////
   // checks

   a_reset_float: assert property (@(posedge mclk_in) // RQ7
      !rstn_in |=> !local_addr_data_lines_oe_out)
      else $error("lines driven after reset edge");

   a_hold_float: assert property (@(posedge mclk_in) disable iff (!rstn_in) // RQ8
      hold_ack_out |-> !local_addr_data_lines_oe_out)
      else $error("lines driven during hold");

   a_addr_word: assert property (@(posedge mclk_in) disable iff (!rstn_in) // RQ2
      (req_valid_in && req_ready_out) |=>
         (!address_strobe_n_out && local_addr_data_lines_oe_out &&
          local_addr_data_lines_out[AD_W-1:ADDR_LSB] == $past(req_addr_in) &&
          local_addr_data_lines_out[ADDR_LSB-1:0] == $past(req_count_in)))
      else $error("address cycle content wrong");

   a_strobe_single: assert property (@(posedge mclk_in) disable iff (!rstn_in) // RQ13
      !address_strobe_n_out |-> (st == ST_ADDR) ##1 address_strobe_n_out)
      else $error("strobe not exactly one address cycle");

   a_read_release: assert property (@(posedge mclk_in) disable iff (!rstn_in) // RQ14
      (st == ST_DATA && !is_write) |-> !local_addr_data_lines_oe_out)
      else $error("lines driven in read data cycle");

   a_write_fill: assert property (@(posedge mclk_in) disable iff (!rstn_in) // RQ5
      (st == ST_DATA && is_write) |->
         (local_addr_data_lines_oe_out &&
          (local_addr_data_lines_out & ~$past(be_mask)) == AD_ZERO))
      else $error("unused write lane not zero");

   a_halt_steady: assert property (@(posedge mclk_in) disable iff (!rstn_in) // RQ9
      (st == ST_HALT && $past(st) == ST_HALT) |->
         (local_addr_data_lines_oe_out && $stable(local_addr_data_lines_out)))
      else $error("lines changed while halted");

   a_halt_addr: assert property (@(posedge mclk_in) disable iff (!rstn_in) // RQ12
      (st == ST_HALT && $past(st) == ST_IDLE) |->
         local_addr_data_lines_out[AD_W-1:ADDR_LSB] ==
            (last_write ? last_wdata[AD_W-1:ADDR_LSB] : last_word[AD_W-1:ADDR_LSB]))
      else $error("halt value wrong");

   a_beat_end: assert property (@(posedge mclk_in) disable iff (!rstn_in) // RQ11
      (take && beat == count) |=> (st == ST_IDLE && !local_addr_data_lines_oe_out))
      else $error("transfer count not honoured");
endmodule

// *** verif/lbm_mem_model.sv ***
// local memory model facing the address/data mux pins
// assumes the mux drives strobe and lines on the rising edge of mclk_in
`timescale 1ns/1ps
module lbm_mem_model (
   input  wire logic        mclk_in,
   input  wire logic        strobe_n_in,
   input  wire logic        dut_oe_in,
   input  wire logic [31:0] dut_lines_in,
   input  wire logic [3:0]  wait_cyc_in,
   output logic             ready_n_out,
   output logic [31:0]      bus_out
);
   logic [31:0] drv;
   logic [31:0] last = 32'h0;
   logic        drv_en;
   logic [29:0] a;
   logic [1:0]  n;
   // an undriven wire shows the inverse of its last level
   assign bus_out = dut_oe_in ? dut_lines_in : (drv_en ? drv : ~last);
   always @(posedge mclk_in) if (dut_oe_in || drv_en) last <= bus_out;
   initial begin
      ready_n_out = 1'b1;
      drv_en = 1'b0;
      drv = 32'h0;
      forever begin
         @(posedge mclk_in);
         if (strobe_n_in === 1'b0) begin
            a = dut_lines_in[31:2];
            // only core-started accesses reach this model, so the count is trusted
            n = dut_lines_in[1:0];
            for (int b = 0; b <= n; b++) begin
               repeat (wait_cyc_in) @(negedge mclk_in);
               @(negedge mclk_in);
               drv = 32'hC3C3_0000 ^ {a, b[1:0]};
               drv_en = 1'b1;
               ready_n_out = 1'b0;
               @(negedge mclk_in);
               ready_n_out = 1'b1;
               repeat (2) @(negedge mclk_in);
               drv_en = 1'b0;
            end
         end
      end
   end
endmodule

// *** verif/lbm_ad_mux_test.sv ***
// self-checking bench for the local bus address/data mux
// assumes the memory model answers every beat with one ready pulse
`timescale 1ns/1ps
module lbm_ad_mux_test;
   import lbm_pkg::*;
   logic mclk = 0, rstn = 0, vld = 0, wr = 0, halt = 0, hreq = 0;
   logic rdy, take, rv, hack, rdyn, oe, asn;
   logic [29:0] adr = 0;
   logic [1:0]  cnt = 0;
   logic [31:0] wd = 0, rd, lo, li;
   logic [3:0]  be = 0, wc = 0;
   logic [3:0]  bes[4] = '{4'hF, 4'h1, 4'h6, 4'hC};
   int n_mismatch = 0, checked = 0;
   initial forever #20 mclk = ~mclk;
   lbm_ad_mux lbm_ad_mux_inst (.mclk_in(mclk), .rstn_in(rstn), .req_valid_in(vld),
      .req_ready_out(rdy), .req_write_in(wr), .req_addr_in(adr), .req_count_in(cnt),
      .wr_data_in(wd), .wr_be_in(be), .wr_take_out(take), .rd_data_out(rd),
      .rd_valid_out(rv), .halt_in(halt), .hold_req_in(hreq), .hold_ack_out(hack),
      .ready_n_in(rdyn), .local_addr_data_lines_in(li), .local_addr_data_lines_out(lo),
      .local_addr_data_lines_oe_out(oe), .address_strobe_n_out(asn));
   lbm_mem_model lbm_mem_model_inst (.mclk_in(mclk), .strobe_n_in(asn), .dut_oe_in(oe),
      .dut_lines_in(lo), .wait_cyc_in(wc), .ready_n_out(rdyn), .bus_out(li));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(string s, logic [31:0] e, logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic tick(int k);
      repeat (k) @(negedge mclk);
   endtask
   function automatic logic [31:0] mask(logic [31:0] d, logic [3:0] m);
      for (int l = 0; l < 4; l++) mask[8*l+:8] = m[l] ? d[8*l+:8] : LANE_FILL;
   endfunction
   // one request: address cycle, then all beats
   task automatic xfer(logic w, logic [29:0] a, logic [1:0] c, logic [31:0] d,
                       logic [3:0] m);
      int i, b;
      vld = 1; wr = w; adr = a; cnt = c; wd = d; be = m;
      for (i = 0; rdy !== 1'b1 && i < 50; i++) tick(1);
      if (i == 50) begin chk("req ready", 32'h1, 32'(rdy)); tally_and_finish; end
      tick(1);
      vld = 0;
      chk("strobe", 32'h0, 32'(asn));
      chk("addr", {a, c}, lo);
      chk("oe", 32'h1, 32'(oe));
      tick(1);
      chk("strobe", 32'h1, 32'(asn));
      chk("oe", 32'(w), 32'(oe));
      if (w) chk("wdata", mask(d, m), lo);
      b = 0;
      for (i = 0; i < 200 && b <= c; i++) begin
         if (w ? take === 1'b1 : rv === 1'b1) begin
            if (!w) chk("rdata", 32'hC3C3_0000 ^ {a, b[1:0]}, rd);
            b++;
         end
         tick(1);
      end
      if (b <= c) begin chk("beat count", 32'(c) + 1, 32'(b)); tally_and_finish; end
      chk("beats", 32'(c) + 1, 32'(b));
      tick(2);
   endtask
   task automatic halt_t(logic [31:0] e);
      halt = 1;
      tick(3);
      chk("halt oe", 32'h1, 32'(oe));
      chk("halt lines", e, lo);
      chk("halt ready", 32'h0, 32'(rdy));
      tick(5);
      chk("halt lines", e, lo);
      halt = 0;
      tick(3);
      chk("idle oe", 32'h0, 32'(oe));
   endtask
   task automatic hold_t;
      int i;
      hreq = 1;
      for (i = 0; hack !== 1'b1 && i < 10; i++) tick(1);
      if (i == 10) begin chk("hold ack", 32'h1, 32'(hack)); tally_and_finish; end
      chk("hold oe", 32'h0, 32'(oe));
      chk("hold ready", 32'h0, 32'(rdy));
      hreq = 0;
      tick(6);
      chk("hold ack", 32'h0, 32'(hack));
   endtask
   task automatic reset_mid;
      wc = 4'h8;
      vld = 1; wr = 1; adr = 30'h0000_0ABC; cnt = 2'h3;
      tick(4);
      vld = 0;
      chk("oe", 32'h1, 32'(oe));
      rstn = 0;
      tick(1);
      chk("reset oe", 32'h0, 32'(oe));
      chk("reset strobe", 32'h1, 32'(asn));
      tick(3);
      rstn = 1;
      tick(2);
      chk("release oe", 32'h0, 32'(oe));
      chk("release ready", 32'h1, 32'(rdy));
      tick(58);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      tick(16);
      chk("reset oe", 32'h0, 32'(oe));
      chk("reset strobe", 32'h1, 32'(asn));
      rstn = 1;
      tick(1);
      for (int k = 0; k < 4; k++) begin
         wc = 4'(k * 3);
         xfer(1, 30'h0ABC_0000 + 30'(k), 2'(k), 32'h1122_3344 + k, bes[k]);
         xfer(0, 30'h0123_4560 + 30'(k), 2'(k), 32'h0, 4'hF);
      end
      halt_t({30'h0123_4563, 2'h3});
      xfer(1, 30'h0000_0055, 2'h1, 32'hDEAD_BEEF, 4'h3);
      halt_t({30'h0000_2FBB, 2'h1});
      hold_t;
      reset_mid;
      xfer(0, 30'h0000_0777, 2'h0, 32'h0, 4'hF);
      tally_and_finish;
   end
endmodule
